// [core/acrc_top.sv]
/*
 * convert and read control of a 12-bit sampling converter with a
 * three-state parallel result bus, chip select and read/convert pins.
 * assumes: pins are asynchronous to the 250 MHz core clock; the sample
 * word arrives on the core clock already in two's complement code.
 */
// Contract
// - both pins low 40ns starts conversion
// - busy low until result register updated
// - busy falls within 125ns of start
// - requests ignored while busy low
// - two's complement result, sign on bit 11
// - bus driven only read, selected, idle
// - whole 12-bit word presented at once
// - busy rises after output register updated
// - select and convert combined as OR
// - select high means nothing, bus released
// - select falling with convert low starts
// - convert falling with select low starts, releases
// - select falling with read high drives result
// - result driven as soon as conversion ends
// - both low after conversion keeps result, released
// - select tied low works with convert alone
`timescale 1ns/10ps
`include "acrc_defines.svh"

module acrc_top
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // host control pins
  input wire logic CS_N_I,
  input wire logic RC_N_I,
  // sampled code from the converter array
  input wire logic [`ACRC_RES_W-1:0] SAMPLE_I,
  // status and result pins
  output logic BUSY_N_O,
  output logic [`ACRC_RES_W-1:0] RESULT_O,
  output logic RESULT_OE_O
);

  // ***********************************************
  // pin synchronisers
  // ***********************************************

  logic cs_lvl;
  logic rc_lvl;

  // chip select level
  acrc_sync u_cs_sync
  (
    .CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I),
    .PIN_I(CS_N_I),
    .LVL_O(cs_lvl)
  );

  // read/convert level
  acrc_sync u_rc_sync
  (
    .CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I),
    .PIN_I(RC_N_I),
    .LVL_O(rc_lvl)
  );

  // ***********************************************
  // control state
  // ***********************************************

  acrc_pkg::acrc_core_t cur;
  acrc_pkg::acrc_core_t next_cur;
  logic combo;
  logic idle;

  // either pin going low last completes the request
  assign combo = !cs_lvl && !rc_lvl;
  assign idle = (cur.st == acrc_pkg::ACRC_IDLE);

  // next state: qualify, convert, update, release
  always_comb
  begin
    next_cur = cur;
    unique case (cur.st)
      acrc_pkg::ACRC_IDLE:
      begin
        if (!combo)
        begin
          // request removed: a fresh one may start
          next_cur.armed = 1'h1;
          next_cur.qual = `ACRC_QUAL_W'(0);
        end
        else if (cur.armed)
        begin
          // level held long enough: hold sample, start
          if (cur.qual == `ACRC_QUAL_W'(`ACRC_PULSE_MIN_CYC - 1))
          begin
            next_cur.st = acrc_pkg::ACRC_CONV;
            next_cur.held = SAMPLE_I;
            next_cur.cnt = `ACRC_CNT_W'(0);
            next_cur.armed = 1'h0;
            next_cur.qual = `ACRC_QUAL_W'(0);
          end
          else
          begin
            next_cur.qual = cur.qual + `ACRC_QUAL_W'(1);
          end
        end
      end
      acrc_pkg::ACRC_CONV:
      begin
        // pins are not looked at while converting
        next_cur.cnt = cur.cnt + `ACRC_CNT_W'(1);
        if (cur.cnt == `ACRC_CNT_W'(`ACRC_CONV_CYC - 1))
        begin
          // whole word into the output register at once
          next_cur.result = cur.held;
          next_cur.st = acrc_pkg::ACRC_DONE;
        end
      end
      acrc_pkg::ACRC_DONE:
      begin
        // register updated one cycle before busy rises
        next_cur.st = acrc_pkg::ACRC_IDLE;
        if (!combo)
        begin
          next_cur.armed = 1'h1;
        end
      end
      default:
      begin
        next_cur.st = acrc_pkg::ACRC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      cur.st <= acrc_pkg::ACRC_IDLE;
      cur.armed <= 1'h0;
      cur.qual <= `ACRC_QUAL_W'(0);
      cur.cnt <= `ACRC_CNT_W'(0);
      cur.held <= `ACRC_RES_RST;
      cur.result <= `ACRC_RES_RST;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************

  // busy low from start until after the update
  assign BUSY_N_O = idle;

  // bus enabled only when selected, reading, idle
  assign RESULT_OE_O = !cs_lvl && rc_lvl && idle;

  // result word straight from the output register
  assign RESULT_O = cur.result;

  // ***********************************************
  // assertions
  // ***********************************************

  default clocking acrc_cb @(posedge CLOCK_I);
  endclocking

  default disable iff (!NRST_I);

  logic pin_combo;
  assign pin_combo = !CS_N_I && !RC_N_I;

  // a request held at the pins for sixteen cycles
  sequence s_pin_req;
    pin_combo[*8] ##1 pin_combo[*8];
  endsequence

  // a qualified request seen by the controller
  sequence s_qual_req;
    (idle && cur.armed && combo)[*8] ##1 (idle && cur.armed && combo)[*2];
  endsequence

  // one full busy period of the conversion
  sequence s_busy_period;
    ##240 !BUSY_N_O ##1 BUSY_N_O;
  endsequence

  AST_START_AFTER_HOLD: assert property (
    s_qual_req |=> !BUSY_N_O)
  else $error("qualified request did not start a conversion");

  AST_NO_SHORT_START: assert property (
    $fell(BUSY_N_O) |-> $past(combo, 1) && $past(combo, 10))
  else $error("conversion started without a held request");

  AST_BUSY_LENGTH: assert property (
    $fell(BUSY_N_O) |-> s_busy_period)
  else $error("busy low time is not the conversion time");

  AST_BUSY_DELAY: assert property (
    ($rose(pin_combo) && idle && cur.armed) ##1 s_pin_req |-> ##[0:15] !BUSY_N_O)
  else $error("busy did not fall within the start delay");

  AST_IGNORE_BUSY: assert property (
    (cur.st == acrc_pkg::ACRC_CONV) |-> !cur.armed && cur.qual == `ACRC_QUAL_W'(0))
  else $error("request tracked during a conversion");

  AST_NO_BACK_TO_BACK: assert property (
    $rose(BUSY_N_O) |-> BUSY_N_O[*8])
  else $error("conversion restarted right after release");

  AST_RESULT_CODE: assert property (
    $fell(BUSY_N_O) |-> ##241 (BUSY_N_O && RESULT_O == $past(SAMPLE_I, 242)))
  else $error("result is not the held sample code");

  AST_NO_DRIVE_BUSY: assert property (
    !BUSY_N_O |-> !RESULT_OE_O)
  else $error("result bus driven during a conversion");

  AST_DESELECT_FLOAT: assert property (
    CS_N_I[*5] |-> !RESULT_OE_O)
  else $error("result bus driven while deselected");

  AST_CONVERT_FLOAT: assert property (
    (!RC_N_I)[*5] |-> !RESULT_OE_O)
  else $error("result bus driven while convert is low");

  AST_READ_DRIVE: assert property (
    (!CS_N_I && RC_N_I && BUSY_N_O)[*6] |-> RESULT_OE_O)
  else $error("result bus not driven for a read");

  AST_DRIVE_ON_DONE: assert property (
    $rose(BUSY_N_O) && !cs_lvl && rc_lvl |-> RESULT_OE_O)
  else $error("result bus not driven when conversion ended");

  AST_UPDATE_BEFORE_RISE: assert property (
    $rose(BUSY_N_O) |-> RESULT_O == $past(cur.held) && $stable(RESULT_O))
  else $error("busy rose before the register update");

  AST_OR_START: assert property (
    $fell(BUSY_N_O) |-> $past(!cs_lvl) && $past(!rc_lvl))
  else $error("conversion started without both inputs low");

  AST_KEEP_AFTER_DONE: assert property (
    $rose(BUSY_N_O) && $past(combo) ##1 combo[*8] |-> BUSY_N_O && !RESULT_OE_O)
  else $error("held low pins restarted or drove the bus");

  // ***********************************************
  // state and datapath checks
  // ***********************************************

  // last qualifying cycle of a request
  sequence s_ready_start;
    idle && cur.armed && combo && cur.qual == `ACRC_QUAL_W'(`ACRC_PULSE_MIN_CYC - 1);
  endsequence

  // busy released while the request is still held
  sequence s_release;
    $rose(BUSY_N_O) && $past(combo);
  endsequence

  AST_STATE_LEGAL: assert property (
    cur.st inside {acrc_pkg::ACRC_IDLE, acrc_pkg::ACRC_CONV, acrc_pkg::ACRC_DONE})
  else $error("controller in an illegal state");

  AST_CNT_RANGE: assert property (
    (cur.st == acrc_pkg::ACRC_CONV) |-> cur.cnt < `ACRC_CNT_W'(`ACRC_CONV_CYC))
  else $error("conversion counter out of range");

  AST_RESULT_STEADY: assert property (
    (cur.st != acrc_pkg::ACRC_DONE) |-> $stable(RESULT_O))
  else $error("result word changed outside the update");

  AST_HELD_STEADY: assert property (
    (cur.st == acrc_pkg::ACRC_CONV) && $past(cur.st == acrc_pkg::ACRC_CONV) |-> $stable(cur.held))
  else $error("held sample changed during a conversion");

  AST_HELD_CAPTURE: assert property (
    $fell(BUSY_N_O) |-> cur.held == $past(SAMPLE_I))
  else $error("sample not captured at the start");

  AST_DONE_ONE_CYCLE: assert property (
    (cur.st == acrc_pkg::ACRC_DONE) |=> idle)
  else $error("update cycle did not release busy");

  AST_CONV_FROM_ZERO: assert property (
    $fell(BUSY_N_O) |-> cur.cnt == `ACRC_CNT_W'(0))
  else $error("conversion counter not cleared at start");

  AST_CS_START: assert property (
    s_ready_start |=> !BUSY_N_O)
  else $error("held request did not start");

  AST_RC_START_FLOAT: assert property (
    s_ready_start |=> !BUSY_N_O && !RESULT_OE_O)
  else $error("start did not release the result bus");

  AST_TIED_SELECT: assert property (
    (!cs_lvl && rc_lvl && BUSY_N_O) |-> RESULT_OE_O)
  else $error("read level did not drive the bus");

  AST_REARM: assert property (
    idle && !combo |=> cur.armed)
  else $error("released request did not re-arm");

  AST_QUAL_BOUND: assert property (
    idle |-> cur.qual < `ACRC_QUAL_W'(`ACRC_PULSE_MIN_CYC))
  else $error("pulse qualifier overran");

  AST_OE_NEEDS_READ: assert property (
    RESULT_OE_O |-> !cs_lvl && rc_lvl && BUSY_N_O)
  else $error("bus enabled outside a read");

  AST_DESELECT_NO_START: assert property (
    idle && cs_lvl |=> idle)
  else $error("deselected device started");

  AST_READ_NO_START: assert property (
    idle && rc_lvl |=> idle)
  else $error("read level started a conversion");

  AST_DONE_UPDATE: assert property (
    (cur.st == acrc_pkg::ACRC_DONE) |-> RESULT_O == cur.held)
  else $error("output register not updated before release");

  AST_CONV_TO_DONE: assert property (
    (cur.st == acrc_pkg::ACRC_CONV && cur.cnt == `ACRC_CNT_W'(`ACRC_CONV_CYC - 1)) |=>
      cur.st == acrc_pkg::ACRC_DONE)
  else $error("conversion did not end on time");

  AST_SIGN_BIT: assert property (
    (cur.st == acrc_pkg::ACRC_DONE) |-> RESULT_O[`ACRC_RES_W-1] == cur.held[`ACRC_RES_W-1])
  else $error("sign bit not on the top result bit");

  AST_HOLD_NO_RESTART: assert property (
    s_release |-> !cur.armed)
  else $error("held request re-armed at release");

endmodule : acrc_top

// [core/acrc_defines.svh]
/*
 * named constants of the convert/read control: widths, timing figures
 * and the cycle counts derived from them at the core clock rate.
 * assumes a single 250 MHz core clock; included by bare name.
 */
`ifndef ACRC_DEFINES_SVH
`define ACRC_DEFINES_SVH

// ***********************************************
// widths
// ***********************************************
`define ACRC_RES_W 12
`define ACRC_CNT_W 8
`define ACRC_QUAL_W 4

// ***********************************************
// timing figures and derived cycle counts
// ***********************************************
`define ACRC_CLK_NS 4
`define ACRC_PULSE_MIN_NS 40
`define ACRC_PULSE_MIN_CYC ((`ACRC_PULSE_MIN_NS + `ACRC_CLK_NS - 1) / `ACRC_CLK_NS)
`define ACRC_CONV_NS 960
`define ACRC_CONV_CYC (`ACRC_CONV_NS / `ACRC_CLK_NS)
`define ACRC_BUSY_MAX_NS 125
`define ACRC_BUSY_MAX_CYC (`ACRC_BUSY_MAX_NS / `ACRC_CLK_NS)

// ***********************************************
// reset values
// ***********************************************
`define ACRC_PIN_IDLE 1'h1
`define ACRC_RES_RST 12'h000

`endif

// [core/acrc_pkg.sv]
/*
 * types of the convert/read control: state encoding and the packed
 * state records of the core and of the pin synchroniser.
 * assumes acrc_defines.svh is on the include path.
 */
`include "acrc_defines.svh"

package acrc_pkg;

  // ***********************************************
  // control states, gray along idle-conv-done
  // ***********************************************
  typedef enum logic [1:0] {
    ACRC_IDLE = 2'h0,
    ACRC_CONV = 2'h1,
    ACRC_DONE = 2'h3
  } acrc_state_t;

  // ***********************************************
  // synchroniser record
  // ***********************************************
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
  } acrc_sync_t;

  // ***********************************************
  // core record
  // ***********************************************
  typedef struct packed {
    acrc_state_t st;
    logic armed;
    logic [`ACRC_QUAL_W-1:0] qual;
    logic [`ACRC_CNT_W-1:0] cnt;
    logic [`ACRC_RES_W-1:0] held;
    logic [`ACRC_RES_W-1:0] result;
  } acrc_core_t;

endpackage : acrc_pkg

// [core/acrc_sync.sv]
/*
 * three flip-flop synchroniser for one pin; the level moves only when
 * the second and third stages agree.
 * assumes an asynchronous pin and the core clock.
 */
`timescale 1ns/10ps
`include "acrc_defines.svh"

module acrc_sync
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // pin and filtered level
  input wire logic PIN_I,
  output logic LVL_O
);

  acrc_pkg::acrc_sync_t cur;
  acrc_pkg::acrc_sync_t next_cur;

  // shift chain, level taken on agreement of stages two and three
  always_comb
  begin
    next_cur = cur;
    next_cur.ff1 = PIN_I;
    next_cur.ff2 = cur.ff1;
    next_cur.ff3 = cur.ff2;
    if (cur.ff2 == cur.ff3)
    begin
      next_cur.lvl = cur.ff3;
    end
  end

  // state register, pins idle high
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      cur <= {4{`ACRC_PIN_IDLE}};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign LVL_O = cur.lvl;

endmodule : acrc_sync

// [tb/acrc_host.sv]
/* host model: drives the select and read/convert pins.
   assumes the core clock; the bench calls its tasks. */
`timescale 1ns/10ps
module acrc_host
(
  // clock
  input wire logic CLOCK_I,
  // control pins
  output logic CS_N_O,
  output logic RC_N_O
);
  // ****
  // pins; the result bus is never driven here
  // ****
  initial
  begin
    CS_N_O = 1'h1;
    RC_N_O = 1'h1;
  end
  // set both pins now
  task set(input logic cs, input logic rc);
    CS_N_O = cs;
    RC_N_O = rc;
  endtask : set
  // set both pins after a falling edge
  task drive(input logic cs, input logic rc);
    @(negedge CLOCK_I);
    set(cs, rc);
  endtask : drive
  // convert request; with via_cs, read/convert low 4 cycles before select falls
  task request(input bit via_cs);
    if (via_cs)
    begin
      drive(1'h1, 1'h0);
      repeat (3) @(negedge CLOCK_I);
    end
    drive(1'h0, 1'h0);
  endtask : request
endmodule : acrc_host

// [tb/adc_convert_read_control_test.sv]
/* self-checking bench of the convert/read control.
   assumes the core files and acrc_host.sv compiled first. */
`timescale 1ns/10ps
`include "acrc_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module adc_convert_read_control_test;
  logic clk;
  logic nrst;
  logic cs_n;
  logic rc_n;
  logic [`ACRC_RES_W-1:0] sample;
  logic busy_n;
  logic [`ACRC_RES_W-1:0] result;
  logic oe;
  wire [`ACRC_RES_W-1:0] bus;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 82;
  int n;
  int r;
  logic ok;
  logic [`ACRC_RES_W-1:0] last;
  logic [`ACRC_RES_W-1:0] exp_q[$];
  logic [`ACRC_RES_W-1:0] codes[6];
  // ****
  // wiring
  // ****
  assign bus = oe ? result : 'z;
  acrc_host HOST (.CLOCK_I(clk), .CS_N_O(cs_n), .RC_N_O(rc_n));
  acrc_top DUT (.CLOCK_I(clk), .NRST_I(nrst), .CS_N_I(cs_n), .RC_N_I(rc_n),
    .SAMPLE_I(sample), .BUSY_N_O(busy_n), .RESULT_O(result), .RESULT_OE_O(oe));
  // 250 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // watchdog, about four times the planned run
  initial
  begin
    #40000;
    n_errors++;
    wrap_up();
  end
  // one conversion; hold keeps both pins low past the end
  task conv(input bit via_cs, input bit hold, input logic [11:0] code);
    sample = code;
    exp_q.push_back(code);
    HOST.request(via_cs);
    n = 0;
    while (busy_n !== 1'h0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("busy delay", 1'h1, n >= 10 && n <= 31)
    r = $random(seed);
    sample = r[11:0];
    n = 0;
    ok = 1'h1;
    while (busy_n === 1'h0 && n < 300)
    begin
      if (oe !== 1'h0)
        ok = 1'h0;
      if (n == 50)
        HOST.set(1'h0, 1'h1);
      if (n == 100)
        HOST.set(1'h0, 1'h0);
      if (n == 230 && !hold)
        HOST.set(1'h0, 1'h1);
      @(negedge clk);
      n++;
    end
    `CHK("busy low", 32'hf1, n)
    `CHK("bus idle in busy", 1'h1, ok)
    last = exp_q.pop_front();
    if (hold)
    begin
      `CHK("both low", 1'h0, oe)
      repeat (12) @(negedge clk);
      HOST.set(1'h0, 1'h1);
      repeat (6) @(negedge clk);
    end
    `CHK("result", last, bus)
    repeat (14) @(negedge clk);
    `CHK("no restart", 1'h1, busy_n)
    repeat (80) @(negedge clk);
  endtask : conv
  // main sequence
  initial
  begin
    nrst = 1'h0;
    sample = 12'h000;
    codes = '{12'h7ff, 12'h000, 12'hfff, 12'h800, 12'h000, 12'h000};
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    `CHK("busy reset", 1'h1, busy_n)
    `CHK("oe reset", 1'h0, oe)
    HOST.drive(1'h1, 1'h0);
    repeat (30) @(negedge clk);
    `CHK("deselected busy", 1'h1, busy_n)
    `CHK("deselected oe", 1'h0, oe)
    // pulse shorter than the minimum width
    HOST.drive(1'h0, 1'h0);
    repeat (5) @(negedge clk);
    HOST.set(1'h1, 1'h1);
    repeat (30) @(negedge clk);
    `CHK("short pulse", 1'h1, busy_n)
    r = $random(seed);
    codes[4] = r[11:0];
    r = $random(seed);
    codes[5] = r[11:0];
    for (int i = 0; i < 6; i++)
      conv(i[0], i[1], codes[i]);
    // read by select alone
    HOST.drive(1'h1, 1'h1);
    repeat (8) @(negedge clk);
    `CHK("read off", 1'h0, oe)
    HOST.drive(1'h0, 1'h1);
    repeat (8) @(negedge clk);
    `CHK("read on", last, bus)
    wrap_up();
  end
endmodule : adc_convert_read_control_test
